// ### design/amsr_params.svh
// constants for the multilane serial read-out block
`ifndef AMSR_PARAMS_SVH
`define AMSR_PARAMS_SVH

`define AMSR_WORD_BITS 22

`define AMSR_CLK_SEL_HI 7
`define AMSR_CLK_SEL_LO 6
`define AMSR_RATE_BIT 4
`define AMSR_WIDTH_HI 3
`define AMSR_WIDTH_LO 2
`define AMSR_MODE_HI 1
`define AMSR_MODE_LO 0

`define AMSR_WIDTH_DUAL 2'h2
`define AMSR_WIDTH_QUAD 2'h3
`define AMSR_OMODE_EDL 2'h1
`define AMSR_OMODE_SRC 2'h3

`define AMSR_CSEL_HOST 2'h0
`define AMSR_CSEL_INT 2'h1
`define AMSR_CSEL_DIV2 2'h2
`define AMSR_CSEL_DIV4 2'h3

`define AMSR_CTL_RESET 8'h00
`define AMSR_INMODE_RESET 2'h0

`define AMSR_CLK_PERIOD_NS 40
`define AMSR_INTERNAL_CLOCK_PERIOD_NS 160
`define AMSR_INTERNAL_CLOCK_HALF_CYC ((`AMSR_INTERNAL_CLOCK_PERIOD_NS / 2) / `AMSR_CLK_PERIOD_NS)

`endif

// ### design/amsr_pkg.sv
// types for the multilane serial read-out block
package amsr_pkg;
  typedef logic [7:0] amsr_ctl_t;
  typedef logic [1:0] amsr_inmode_t;
  typedef enum {AMSR_IDLE, AMSR_FRAME} amsr_state_e;
endpackage

// ### design/amsr_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module amsr_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic din,
  output logic dout
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // only a level seen by two later stages counts
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dout <= RESET_VAL;
    end else if (s2_reg == s3_reg) begin
      dout <= s3_reg;
    end
  end
endmodule

// ### design/amsr_tick_div.sv
// free-running divider giving a one-cycle enable pulse
`timescale 1ns/1ps
module amsr_tick_div #(
  parameter int DIV = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  output logic tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_reg;

  if (DIV < 1) begin : g_chk
    $error("amsr_tick_div: DIV must be at least 1");
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else if (cnt_reg == LAST) begin
      cnt_reg <= '0;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + CW'(1);
      tick <= 1'b0;
    end
  end
endmodule

// ### design/amsr_readout.sv
// device-side serial read-out of the conversion word over one, two or four lanes
`timescale 1ns/1ps
`include "amsr_params.svh"

// Summary of operation
// - legacy modes offer one, two or four lanes
// - dual drives two bits, quad four bits
// - msb at cs fall or first clock edge
// - early launch only with input modes 00/10
// - early launch presents bits half clock sooner
// - ready pin low through spi frames
// - zeros follow word in non-daisy modes
// - source-synchronous mode drives clock aligned with data
// - ready pin carries output clock in src
// - output clock from host or divided internal
// - src modes also offer selectable lane width
// - src launches lane bits on rising edges
// - clock source field is top two bits
// - internal clock sources serve zone one only
// - rate bit picks rising only or both edges
module amsr_readout
  import amsr_pkg::*;
#(
  parameter int WORD_BITS = `AMSR_WORD_BITS,
  parameter int INTERNAL_CLOCK_HALF_CYC = `AMSR_INTERNAL_CLOCK_HALF_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [WORD_BITS-1:0] conversion_data,
  input wire amsr_pkg::amsr_inmode_t input_protocol_mode,
  input wire amsr_pkg::amsr_ctl_t output_control_register,
  input wire logic zone2_transfer,
  output logic data_lane_0,
  output logic data_lane_1,
  output logic data_lane_2,
  output logic data_lane_3,
  output logic ready_output_clock_pin,
  output logic frame_active,
  output logic clock_source_refused
);
  import amsr_pkg::*;

  localparam int SR_BITS = ((WORD_BITS + 3) / 4) * 4;
  localparam int PAD_BITS = SR_BITS - WORD_BITS;
  localparam logic [5:0] LAUNCH_SINGLE = 6'(WORD_BITS);
  localparam logic [5:0] LAUNCH_DUAL = 6'((WORD_BITS + 1) / 2);
  localparam logic [5:0] LAUNCH_QUAD = 6'((WORD_BITS + 3) / 4);

  if (WORD_BITS < 4 || WORD_BITS > 63) begin : g_chk_word
    $error("amsr_readout: WORD_BITS must lie in 4..63");
  end
  if (INTERNAL_CLOCK_HALF_CYC < 1) begin : g_chk_div
    $error("amsr_readout: INTERNAL_CLOCK_HALF_CYC must be at least 1");
  end

  logic cs_n_s;
  logic sclk_s;
  logic cs_n_d_reg;
  logic sclk_d_reg;
  logic int_tick;

  amsr_sync3 #(.RESET_VAL(1'b1)) u_sync_cs (
    .clk(clk),
    .reset_n(reset_n),
    .din(cs_n),
    .dout(cs_n_s)
  );

  amsr_sync3 #(.RESET_VAL(1'b0)) u_sync_sclk (
    .clk(clk),
    .reset_n(reset_n),
    .din(sclk),
    .dout(sclk_s)
  );

  // base half-period of the internal clock
  amsr_tick_div #(.DIV(INTERNAL_CLOCK_HALF_CYC)) u_internal_clock (
    .clk(clk),
    .reset_n(reset_n),
    .tick(int_tick)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_n_d_reg <= 1'b1;
      sclk_d_reg <= 1'b0;
    end else begin
      cs_n_d_reg <= cs_n_s;
      sclk_d_reg <= sclk_s;
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;

  assign cs_fall = cs_n_d_reg & ~cs_n_s;
  assign cs_rise = ~cs_n_d_reg & cs_n_s;
  assign sclk_rise = ~sclk_d_reg & sclk_s;
  assign sclk_fall = sclk_d_reg & ~sclk_s;

  amsr_state_e state_reg;
  amsr_ctl_t ctl_reg;
  amsr_inmode_t inmode_reg;
  logic refused_reg;

  // settings are frozen for the frame so a mid-frame write cannot tear the word
  amsr_ctl_t ctl_cur;
  amsr_inmode_t inmode_cur;
  assign ctl_cur = cs_fall ? output_control_register : ctl_reg;
  assign inmode_cur = cs_fall ? input_protocol_mode : inmode_reg;

  logic [1:0] width_cur;
  logic [1:0] omode_cur;
  logic [1:0] csel_cur;
  logic ddr_cur;
  logic is_src;
  logic edl_on;
  logic msb_on_edge;
  logic legacy_launch_rise;
  logic in_frame;

  assign width_cur = ctl_cur[`AMSR_WIDTH_HI:`AMSR_WIDTH_LO];
  assign omode_cur = ctl_cur[`AMSR_MODE_HI:`AMSR_MODE_LO];
  assign csel_cur = ctl_cur[`AMSR_CLK_SEL_HI:`AMSR_CLK_SEL_LO];
  assign ddr_cur = ctl_cur[`AMSR_RATE_BIT];
  assign is_src = (omode_cur == `AMSR_OMODE_SRC);
  assign edl_on = (omode_cur == `AMSR_OMODE_EDL) && !inmode_cur[0];
  assign msb_on_edge = inmode_cur[0];
  assign legacy_launch_rise = (^inmode_cur) ^ edl_on;
  assign in_frame = (state_reg == AMSR_FRAME);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= AMSR_IDLE;
    end else begin
      case (state_reg)
        AMSR_IDLE: begin
          if (cs_fall) begin
            state_reg <= AMSR_FRAME;
          end
        end
        AMSR_FRAME: begin
          if (cs_rise) begin
            state_reg <= AMSR_IDLE;
          end
        end
        default: begin
          state_reg <= AMSR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_reg <= `AMSR_CTL_RESET;
      inmode_reg <= `AMSR_INMODE_RESET;
      refused_reg <= 1'b0;
    end else if (cs_fall) begin
      ctl_reg <= output_control_register;
      inmode_reg <= input_protocol_mode;
      refused_reg <= (output_control_register[`AMSR_MODE_HI:`AMSR_MODE_LO] == `AMSR_OMODE_SRC) &&
                     (output_control_register[`AMSR_CLK_SEL_HI:`AMSR_CLK_SEL_LO] != `AMSR_CSEL_HOST) &&
                     zone2_transfer;
    end
  end

  // host keeps command use and clock count; frame runs on what it gets

  logic [1:0] pre_reg;
  logic int_step;
  logic rclk_reg;
  logic [5:0] left_reg;
  logic src_ok;
  logic int_active;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_reg <= 2'h0;
    end else if (cs_fall) begin
      pre_reg <= 2'h0;
    end else if (int_tick) begin
      pre_reg <= pre_reg + 2'h1;
    end
  end

  always_comb begin
    case (csel_cur)
      `AMSR_CSEL_INT: int_step = int_tick;
      `AMSR_CSEL_DIV2: int_step = int_tick && pre_reg[0];
      `AMSR_CSEL_DIV4: int_step = int_tick && (pre_reg == 2'h3);
      default: int_step = 1'b0;
    endcase
  end

  assign src_ok = !refused_reg;
  assign int_active = in_frame && is_src && src_ok && (csel_cur != `AMSR_CSEL_HOST);

  logic legacy_launch;
  logic host_launch;
  logic int_launch;
  logic int_toggle;
  logic launch;

  assign legacy_launch = !is_src &&
                         ((cs_fall && !msb_on_edge) ||
                          (in_frame && (legacy_launch_rise ? sclk_rise : sclk_fall)));
  assign host_launch = in_frame && is_src && src_ok && (csel_cur == `AMSR_CSEL_HOST) &&
                       (sclk_rise || (ddr_cur && sclk_fall));
  assign int_launch = int_active && int_step && (rclk_reg ? (ddr_cur && left_reg != 6'h0) : (left_reg != 6'h0));
  assign int_toggle = int_active && int_step && (rclk_reg || left_reg != 6'h0);
  assign launch = legacy_launch || host_launch || int_launch;

  logic [5:0] launch_full;
  always_comb begin
    case (width_cur)
      `AMSR_WIDTH_DUAL: launch_full = LAUNCH_DUAL;
      `AMSR_WIDTH_QUAD: launch_full = LAUNCH_QUAD;
      default: launch_full = LAUNCH_SINGLE;
    endcase
  end

  // launches still owed; ends the internal clock burst
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      left_reg <= 6'h0;
    end else if (cs_fall) begin
      left_reg <= launch ? (launch_full - 6'h1) : launch_full;
    end else if (launch && left_reg != 6'h0) begin
      left_reg <= left_reg - 6'h1;
    end
  end

  // internal output clock; parks low once the word is out
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rclk_reg <= 1'b0;
    end else if (cs_fall || !in_frame) begin
      rclk_reg <= 1'b0;
    end else if (int_toggle) begin
      rclk_reg <= ~rclk_reg;
    end
  end

  logic [SR_BITS-1:0] sr_reg;
  logic [SR_BITS-1:0] sr_src;
  logic [3:0] lanes_reg;

  assign sr_src = cs_fall ? {conversion_data, {PAD_BITS{1'b0}}} : sr_reg;

  // zeros shift in behind the word, so a long frame ends in zeros
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sr_reg <= '0;
      lanes_reg <= 4'h0;
    end else if (cs_rise) begin
      lanes_reg <= 4'h0;
    end else if (launch) begin
      case (width_cur)
        `AMSR_WIDTH_QUAD: begin
          lanes_reg <= sr_src[SR_BITS-1 -: 4];
          sr_reg <= {sr_src[SR_BITS-5:0], 4'h0};
        end
        `AMSR_WIDTH_DUAL: begin
          lanes_reg <= {2'h0, sr_src[SR_BITS-1 -: 2]};
          sr_reg <= {sr_src[SR_BITS-3:0], 2'h0};
        end
        default: begin
          lanes_reg <= {3'h0, sr_src[SR_BITS-1]};
          sr_reg <= {sr_src[SR_BITS-2:0], 1'b0};
        end
      endcase
    end else if (cs_fall) begin
      sr_reg <= sr_src;
      lanes_reg <= 4'h0;
    end
  end

  assign data_lane_0 = lanes_reg[0];
  assign data_lane_1 = lanes_reg[1];
  assign data_lane_2 = lanes_reg[2];
  assign data_lane_3 = lanes_reg[3];

  logic rvs_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rvs_reg <= 1'b1;
    end else if (!in_frame && !cs_fall) begin
      rvs_reg <= !is_src;
    end else if (!is_src) begin
      rvs_reg <= 1'b0;
    end else if (!src_ok || cs_fall) begin
      rvs_reg <= 1'b0;
    end else if (csel_cur == `AMSR_CSEL_HOST) begin
      rvs_reg <= sclk_s;
    end else begin
      rvs_reg <= int_toggle ? ~rclk_reg : rclk_reg;
    end
  end

  assign ready_output_clock_pin = rvs_reg;
  assign frame_active = in_frame;
  assign clock_source_refused = refused_reg;
endmodule

// ### test/amsr_readout_monitor.sv
// assertion checker for the multilane read-out block
`timescale 1ns/1ps
module amsr_readout_monitor
  import amsr_pkg::*;
#(
  parameter int WORD_BITS = 22,
  parameter int INTERNAL_CLOCK_HALF_CYC = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [WORD_BITS-1:0] conversion_data,
  input wire amsr_pkg::amsr_inmode_t input_protocol_mode,
  input wire amsr_pkg::amsr_ctl_t output_control_register,
  input wire logic zone2_transfer,
  input wire logic data_lane_0,
  input wire logic data_lane_1,
  input wire logic data_lane_2,
  input wire logic data_lane_3,
  input wire logic ready_output_clock_pin,
  input wire logic frame_active,
  input wire logic clock_source_refused
);
  amsr_ctl_t ctl_q;
  amsr_inmode_t im_q;
  logic [WORD_BITS-1:0] data_q;
  logic [7:0] hi_cnt;
  logic src;
  // follows the inputs while idle, so it freezes on the same edge the design latches
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q <= 8'h00;
      im_q <= 2'h0;
      data_q <= '0;
    end else if (!frame_active) begin
      ctl_q <= output_control_register;
      im_q <= input_protocol_mode;
      data_q <= conversion_data;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_cnt <= 8'h00;
    end else begin
      hi_cnt <= ready_output_clock_pin ? hi_cnt + 8'h01 : 8'h00;
    end
  end
  assign src = ctl_q[1:0] == 2'h3;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence open3;
    frame_active && $past(frame_active) && $past(frame_active, 2);
  endsequence
  sequence start_s;
    $rose(frame_active);
  endsequence
  AST_READY_LOW_SPI: assert property (open3 ##0 !src |-> !ready_output_clock_pin)
    else $error("ready pin high in spi frame");
  AST_SINGLE_LANE: assert property (open3 ##0 ctl_q[3:2] < 2'h2 |-> !(data_lane_1 | data_lane_2 | data_lane_3))
    else $error("unused lane driven in single mode");
  AST_DUAL_LANES: assert property (open3 ##0 ctl_q[3:2] == 2'h2 |-> !(data_lane_2 | data_lane_3))
    else $error("upper lanes driven in dual mode");
  AST_REFUSED_SET: assert property (start_s ##0 src && ctl_q[7:6] != 2'h0 && $past(zone2_transfer)
    |-> ##[0:1] clock_source_refused)
    else $error("internal source not refused in zone two");
  AST_REFUSED_QUIET: assert property (frame_active && clock_source_refused |-> !ready_output_clock_pin && !data_lane_0)
    else $error("refused frame still clocks");
  AST_MSB_AT_CS: assert property (start_s ##0 !im_q[0] && !src && ctl_q[3:2] < 2'h2
    |-> ##[1:2] data_lane_0 == data_q[WORD_BITS-1])
    else $error("msb missing after chip select");
  AST_NO_EARLY_BIT: assert property (start_s ##0 im_q[0] && !src |-> (!data_lane_0 && !data_lane_1) [*3])
    else $error("data launched before first clock edge");
  AST_HOST_CLK_HIGH: assert property ((frame_active && src && ctl_q[7:6] == 2'h0 && sclk) [*8]
    |-> ready_output_clock_pin)
    else $error("output clock not following host clock");
  // the drop at frame start from an idle-high pin is not a clock phase
  AST_INT_HALF: assert property ($fell(ready_output_clock_pin) && frame_active && $past(frame_active) && src &&
    ctl_q[7:6] != 2'h0 |-> hi_cnt == (INTERNAL_CLOCK_HALF_CYC << (ctl_q[7:6] - 2'h1)))
    else $error("internal output clock high phase wrong");
endmodule
bind amsr_readout amsr_readout_monitor #(.WORD_BITS(WORD_BITS), .INTERNAL_CLOCK_HALF_CYC(INTERNAL_CLOCK_HALF_CYC))
  amsr_readout_monitor_i (.clk(clk), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk),
  .conversion_data(conversion_data), .input_protocol_mode(input_protocol_mode),
  .output_control_register(output_control_register), .zone2_transfer(zone2_transfer),
  .data_lane_0(data_lane_0), .data_lane_1(data_lane_1), .data_lane_2(data_lane_2), .data_lane_3(data_lane_3),
  .ready_output_clock_pin(ready_output_clock_pin), .frame_active(frame_active),
  .clock_source_refused(clock_source_refused));

// ### test/amsr_host_model.sv
// host controller model: frames chip select and serial clock, records the pins
`timescale 1ns/1ps
module amsr_host_model #(
  parameter int HALF = 8
) (
  input wire logic clk,
  output logic cs_n,
  output logic sclk,
  input wire logic [4:0] pins
);
  logic [4:0] samp [0:63];
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
  end
  // read frames only, no register commands
  // slow clock keeps every level well past the pin filter
  task automatic frame(input logic pol, input int edges);
    @(negedge clk);
    sclk = pol;
    repeat (HALF) @(negedge clk);
    cs_n = 1'b0;
    for (int k = 0; k <= edges; k++) begin
      repeat (HALF) @(negedge clk);
      samp[k] = pins;
      if (k < edges) sclk = ~sclk;
    end
    cs_n = 1'b1;
    repeat (HALF) @(negedge clk);
  endtask
endmodule

// ### test/amsr_readout_tb.sv
// self-checking bench for the multilane read-out block
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module amsr_readout_tb;
  import amsr_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cs_n, sclk, l0, l1, l2, l3, rdy, fa, refused;
  logic zone2 = 1'b0;
  logic [21:0] data = 22'h2d5a3c;
  amsr_inmode_t imode = 2'h0;
  amsr_ctl_t ctl = 8'h00;
  int error_cnt = 0;
  int compares = 0;
  int rises = 0;
  always #20 clk = ~clk;
  amsr_readout #(.WORD_BITS(22), .INTERNAL_CLOCK_HALF_CYC(2)) amsr_readout_i (.clk(clk), .reset_n(reset_n),
    .cs_n(cs_n), .sclk(sclk), .conversion_data(data), .input_protocol_mode(imode),
    .output_control_register(ctl), .zone2_transfer(zone2), .data_lane_0(l0), .data_lane_1(l1),
    .data_lane_2(l2), .data_lane_3(l3), .ready_output_clock_pin(rdy), .frame_active(fa),
    .clock_source_refused(refused));
  amsr_host_model #(.HALF(8)) amsr_host_model_i (.clk(clk), .cs_n(cs_n), .sclk(sclk),
    .pins({rdy, l3, l2, l1, l0}));
  always @(posedge rdy) if (fa) rises++;
  task automatic close_out();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // kind: 0 launch on second edge, 1 first edge, 2 early launch, 3 both edges, 4 internal clock
  task automatic run(input amsr_ctl_t c, input amsr_inmode_t m, input logic pol, input int kind,
    input int edges, input int exp_rises);
    logic [4:0] e;
    logic [63:0] pad;
    int w;
    int b;
    logic rf;
    @(negedge clk);
    ctl = c;
    imode = m;
    data = {data[20:0], ~data[21]};
    rises = 0;
    amsr_host_model_i.frame(pol, edges);
    pad = {data, 42'h0};
    rf = c[1:0] == 2'h3 && c[7:6] != 2'h0 && zone2;
    w = c[3:2] == 2'h3 ? 4 : (c[3:2] == 2'h2 ? 2 : 1);
    for (int k = 0; k <= edges; k++) begin
      // early launch moves each bit after the msb onto the capture edge, so it still lasts a full clock
      b = kind == 0 ? (k % 2 ? -1 : k / 2) : kind == 1 ? (k % 2 ? k / 2 : -1) : kind == 2 ? (k + 1) / 2 :
          kind == 3 ? k - 1 : (k == edges ? (21 + w) / w - 1 : -1);
      if (b >= 0) begin
        e[3:0] = rf ? 4'h0 : 4'(pad[63 - w * b -: 4] >> (4 - w));
        e[4] = c[1:0] == 2'h3 ? k[0] : 1'b0;
        `CHK(amsr_host_model_i.samp[k], e)
      end
    end
    if (kind == 4) `CHK(rises, exp_rises)
    `CHK(refused, rf)
    `CHK(fa, 1'b0)
  endtask
  initial begin
    #500000;
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (8) @(negedge clk);
    run(8'h00, 2'h0, 1'b0, 0, 48, 0);
    run(8'h08, 2'h0, 1'b0, 0, 26, 0);
    run(8'h0c, 2'h2, 1'b1, 0, 14, 0);
    run(8'h0c, 2'h1, 1'b0, 1, 14, 0);
    run(8'h08, 2'h3, 1'b1, 1, 26, 0);
    run(8'h09, 2'h0, 1'b0, 2, 14, 0);
    run(8'h0d, 2'h2, 1'b1, 2, 8, 0);
    run(8'h09, 2'h1, 1'b0, 1, 26, 0);
    run(8'h04, 2'h0, 1'b0, 0, 48, 0);
    run(8'h03, 2'h0, 1'b0, 1, 48, 0);
    run(8'h0f, 2'h0, 1'b0, 1, 14, 0);
    run(8'h13, 2'h0, 1'b0, 3, 24, 0);
    run(8'h4f, 2'h0, 1'b0, 4, 8, 6);
    run(8'h8b, 2'h0, 1'b0, 4, 14, 11);
    run(8'hdb, 2'h0, 1'b0, 4, 16, 6);
    zone2 = 1'b1;
    run(8'h43, 2'h0, 1'b0, 4, 8, 0);
    run(8'h03, 2'h0, 1'b0, 1, 48, 0);
    close_out();
  end
endmodule
